// File: hw/stage_timer_pkg.sv
// Constants, field positions and types shared by the stage delay timer.
package stage_timer_pkg;
  localparam int CLK_PERIOD_NS   = 100;
  localparam int TICK_NS         = 1000000;
  localparam int TICK_CYCLES     = TICK_NS / CLK_PERIOD_NS;
  localparam int RELEASE_STEP_MS = 5;
  localparam int RESET_RATIO_PCT = 97;
  localparam int PCT_FULL        = 100;
  localparam int RI_A_MILLI      = 339;
  localparam int RI_B_MILLI      = 236;
  localparam int RI_SCALE        = 10000;
  localparam int RD_OFFSET_MS    = 5800;
  localparam int RD_SLOPE_Q8     = 936;
  localparam int LOG_FRAC_BITS   = 8;
  localparam int DIV_STEPS       = 48;

  localparam logic [7:0] ADR_CTRL    = 8'h00;
  localparam logic [7:0] ADR_ISET    = 8'h04;
  localparam logic [7:0] ADR_TDIAL   = 8'h08;
  localparam logic [7:0] ADR_RELEASE = 8'h0C;
  localparam logic [7:0] ADR_STATUS  = 8'h10;
  localparam logic [7:0] ADR_OPTIME  = 8'h14;
  localparam logic [7:0] ADR_DELAY   = 8'h18;
  localparam logic [7:0] ADR_INT_ST  = 8'h1C;
  localparam logic [7:0] ADR_INT_MSK = 8'h20;

  localparam int CTRL_CURVE    = 0;
  localparam int CTRL_DELAYED  = 1;
  localparam int CTRL_OPRST    = 2;
  localparam int CTRL_CONT     = 3;
  localparam int CTRL_FORCE_EN = 4;
  localparam int CTRL_FORCE_LO = 5;
  localparam int CTRL_PHASE_LO = 8;

  localparam logic [15:0] RST_CTRL    = 16'h0006;
  localparam logic [15:0] RST_ISET    = 16'h0078;
  localparam logic [15:0] RST_TDIAL   = 16'h0005;
  localparam logic [15:0] RST_RELEASE = 16'h000C;

  localparam int INT_START  = 0;
  localparam int INT_TRIP   = 1;
  localparam int INT_EXPIRE = 2;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_TIMING  = 3'b010,
    ST_RELEASE = 3'b100
  } stage_state_t;

  typedef enum logic [1:0] {
    FORCE_NORMAL  = 2'h0,
    FORCE_START   = 2'h1,
    FORCE_TRIP    = 2'h2,
    FORCE_BLOCKED = 2'h3
  } force_code_t;
endpackage

// File: hw/operate_delay_calc.sv
// Sequential calculator of the operate delay in milliseconds for both inverse curves.
`timescale 1ns/1ps
module operate_delay_calc (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic        curve_log,
  input  wire logic [15:0] i_meas,
  input  wire logic [15:0] i_set,
  input  wire logic [15:0] t_dial,
  output logic             busy,
  output logic             done,
  output logic [31:0]      delay_ms
);
  logic        [47:0] quo;
  logic        [32:0] rem;
  logic        [31:0] divisor;
  logic        [5:0]  steps;
  logic        [32:0] rem_sh;
  logic signed [33:0] ri_den;
  logic signed [13:0] dlog;
  logic signed [31:0] rd_ms;

  // Piecewise-linear log2 in Q5.8; the error stays below a tenth of an octave.
  function automatic logic [12:0] log2_q(input logic [31:0] x);
    logic [4:0]  p;
    logic [31:0] n;
    p = 5'h00;
    for (int i = 0; i < 32; i++)
      if (x[i])
        p = i[4:0];
    n = x << (5'h1F - p);
    return {p, n[30:23]};
  endfunction

  assign ri_den = 34'(stage_timer_pkg::RI_A_MILLI) * $signed({18'h00000, i_meas})
                - 34'(stage_timer_pkg::RI_B_MILLI) * $signed({18'h00000, i_set});
  assign dlog   = $signed({1'b0, log2_q(32'(i_meas) * 32'(stage_timer_pkg::PCT_FULL))})
                - $signed({1'b0, log2_q(32'(t_dial) * 32'(i_set))});
  assign rd_ms  = (32'sd1 <<< stage_timer_pkg::LOG_FRAC_BITS) * stage_timer_pkg::RD_OFFSET_MS
                - 32'(dlog) * stage_timer_pkg::RD_SLOPE_Q8;
  assign rem_sh = {rem[31:0], quo[47]};

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      busy     <= 1'b0;
      done     <= 1'b0;
      quo      <= 48'h000000000000;
      rem      <= 33'h000000000;
      divisor  <= 32'h00000000;
      steps    <= 6'h00;
      delay_ms <= 32'hFFFFFFFF;
    end
    else
    begin
      done <= 1'b0;
      if (go && !busy)
      begin
        if (curve_log)
        begin
          done <= 1'b1;
          if (t_dial == 16'h0000 || i_set == 16'h0000 || i_meas == 16'h0000)
            delay_ms <= 32'hFFFFFFFF;
          else if (rd_ms < 0)
            delay_ms <= 32'h00000000;
          else
            delay_ms <= 32'(rd_ms >>> stage_timer_pkg::LOG_FRAC_BITS);
        end
        else if (ri_den <= 0)
        begin
          done     <= 1'b1;
          delay_ms <= 32'hFFFFFFFF;
        end
        else
        begin
          busy    <= 1'b1;
          quo     <= 48'(t_dial) * 48'(i_meas) * 48'(stage_timer_pkg::RI_SCALE);
          divisor <= 32'(ri_den);
          rem     <= 33'h000000000;
          steps   <= 6'(stage_timer_pkg::DIV_STEPS);
        end
      end
      else if (busy)
      begin
        if (rem_sh >= {1'b0, divisor})
        begin
          rem <= rem_sh - {1'b0, divisor};
          quo <= {quo[46:0], 1'b1};
        end
        else
        begin
          rem <= rem_sh;
          quo <= {quo[46:0], 1'b0};
        end
        steps <= steps - 6'h01;
        // The result goes out with the last quotient bit, so a stale quotient is never reused.
        if (steps == 6'h01)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          if (quo[46:31] != 16'h0000)
            delay_ms <= 32'hFFFFFFFF;
          else
            delay_ms <= {quo[30:0], rem_sh >= {1'b0, divisor}};
        end
      end
    end
  end
endmodule

// File: hw/stage_delay_timer.sv
// Protection stage timer: pick-up, operate delay, release handling, forcing and Wishbone registers.
//
// The address map and the Wishbone interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module stage_delay_timer #(
  parameter int unsigned TICK_CYCLES = stage_timer_pkg::TICK_CYCLES
) (
  input  wire logic        CLK_SYS,
  input  wire logic        RST,
  input  wire logic [15:0] I_MEAS,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [31:0] WB_DAT_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic        WB_WE_I,
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  output logic             WB_ACK_O,
  output logic [31:0]      WB_DAT_O,
  output logic             START,
  output logic             TRIP,
  output logic             BLOCKED,
  output logic [2:0]       PHASE_MASK,
  output logic             IRQ
);
  logic [15:0]                    ctrl;
  logic [15:0]                    iset;
  logic [15:0]                    tdial;
  logic [15:0]                    rel_steps;
  logic [2:0]                     int_st;
  logic [2:0]                     int_mask;
  logic [2:0]                     events;
  stage_timer_pkg::stage_state_t  state;
  stage_timer_pkg::force_code_t   force_code;
  logic                           pickup;
  logic [22:0]                    im_pct;
  logic [22:0]                    iset_pct;
  logic [13:0]                    tick_cnt;
  logic                           tick;
  logic [31:0]                    op_cnt;
  logic [18:0]                    rel_cnt;
  logic [18:0]                    release_ms;
  logic [31:0]                    delay_ms;
  logic [31:0]                    calc_ms;
  logic                           delay_ok;
  logic                           calc_go;
  logic                           calc_busy;
  logic                           calc_done;
  logic                           real_trip;
  logic                           expire;
  logic                           forcing;
  logic                           blk;
  logic                           bus_req;
  logic                           bus_wr;
  logic [31:0]                    rd_value;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] dat,
                                          input logic [3:0] sel);
    return {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  assign bus_req    = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign bus_wr     = bus_req && WB_WE_I;
  assign forcing    = ctrl[stage_timer_pkg::CTRL_FORCE_EN];
  assign force_code = stage_timer_pkg::force_code_t'(ctrl[stage_timer_pkg::CTRL_FORCE_LO +: 2]);
  assign blk        = forcing && force_code == stage_timer_pkg::FORCE_BLOCKED;
  assign im_pct     = 23'(I_MEAS) * 23'(stage_timer_pkg::PCT_FULL);
  assign iset_pct   = 23'(iset) * 23'(stage_timer_pkg::RESET_RATIO_PCT);
  assign tick       = tick_cnt == 14'(TICK_CYCLES - 1);
  assign release_ms = 19'(rel_steps) * 19'(stage_timer_pkg::RELEASE_STEP_MS);
  // Trip only from the timing state, so a running count in release never trips.
  assign real_trip  = state == stage_timer_pkg::ST_TIMING && pickup && delay_ok
                      && op_cnt >= delay_ms;
  assign expire     = state == stage_timer_pkg::ST_RELEASE && !pickup && !blk
                      && rel_cnt >= release_ms;
  assign events     = {expire, real_trip && !TRIP, state != stage_timer_pkg::ST_IDLE && !START};

  // Wishbone handshake: one wait state, ack dropped in the following cycle.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end
    else
    begin
      WB_ACK_O <= bus_req;
      WB_DAT_O <= bus_req && !WB_WE_I ? rd_value : 32'h00000000;
    end
  end

  always_comb
  begin
    case (WB_ADR_I)
      stage_timer_pkg::ADR_CTRL:    rd_value = {16'h0000, ctrl};
      stage_timer_pkg::ADR_ISET:    rd_value = {16'h0000, iset};
      stage_timer_pkg::ADR_TDIAL:   rd_value = {16'h0000, tdial};
      stage_timer_pkg::ADR_RELEASE: rd_value = {16'h0000, rel_steps};
      stage_timer_pkg::ADR_STATUS:  rd_value = {25'h0000000, delay_ok, state, TRIP, START, pickup};
      stage_timer_pkg::ADR_OPTIME:  rd_value = op_cnt;
      stage_timer_pkg::ADR_DELAY:   rd_value = delay_ms;
      stage_timer_pkg::ADR_INT_ST:  rd_value = {29'h00000000, int_st};
      stage_timer_pkg::ADR_INT_MSK: rd_value = {29'h00000000, int_mask};
      default:                      rd_value = 32'h00000000;
    endcase
  end

  // Settings take effect at once; the delay follows within two calculation passes.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      ctrl      <= stage_timer_pkg::RST_CTRL;
      iset      <= stage_timer_pkg::RST_ISET;
      tdial     <= stage_timer_pkg::RST_TDIAL;
      rel_steps <= stage_timer_pkg::RST_RELEASE;
    end
    else if (bus_wr)
    begin
      case (WB_ADR_I)
        stage_timer_pkg::ADR_CTRL:    ctrl      <= merge16(ctrl, WB_DAT_I, WB_SEL_I);
        stage_timer_pkg::ADR_ISET:    iset      <= merge16(iset, WB_DAT_I, WB_SEL_I);
        stage_timer_pkg::ADR_TDIAL:   tdial     <= merge16(tdial, WB_DAT_I, WB_SEL_I);
        stage_timer_pkg::ADR_RELEASE: rel_steps <= merge16(rel_steps, WB_DAT_I, WB_SEL_I);
        default:                      ctrl      <= ctrl;
      endcase
    end
  end

  // A new event in the cycle of its write-one clear stays set.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      int_st   <= 3'h0;
      int_mask <= 3'h0;
      IRQ      <= 1'b0;
    end
    else
    begin
      if (bus_wr && WB_ADR_I == stage_timer_pkg::ADR_INT_ST && WB_SEL_I[0])
        int_st <= (int_st & ~WB_DAT_I[2:0]) | events;
      else
        int_st <= int_st | events;
      if (bus_wr && WB_ADR_I == stage_timer_pkg::ADR_INT_MSK && WB_SEL_I[0])
        int_mask <= WB_DAT_I[2:0];
      IRQ <= |(int_st & int_mask);
    end
  end

  // The drop level sits at 97 percent so a current near the threshold cannot chatter.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      pickup <= 1'b0;
    else if (I_MEAS > iset)
      pickup <= 1'b1;
    else if (im_pct < iset_pct)
      pickup <= 1'b0;
  end

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
      tick_cnt <= 14'h0000;
    else if (tick)
      tick_cnt <= 14'h0000;
    else
      tick_cnt <= tick_cnt + 14'h0001;
  end

  // The calculator reruns back to back, so the delay trails the current by some microseconds.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      calc_go  <= 1'b0;
      delay_ok <= 1'b0;
      delay_ms <= 32'hFFFFFFFF;
    end
    else
    begin
      calc_go <= !calc_busy && !calc_go;
      if (calc_done)
      begin
        delay_ok <= 1'b1;
        delay_ms <= calc_ms;
      end
    end
  end

  operate_delay_calc calc (
    .clk       (CLK_SYS),
    .rst       (RST),
    .go        (calc_go),
    .curve_log (ctrl[stage_timer_pkg::CTRL_CURVE]),
    .i_meas    (I_MEAS),
    .i_set     (iset),
    .t_dial    (tdial),
    .busy      (calc_busy),
    .done      (calc_done),
    .delay_ms  (calc_ms)
  );

  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      state   <= stage_timer_pkg::ST_IDLE;
      op_cnt  <= 32'h00000000;
      rel_cnt <= 19'h00000;
    end
    else if (blk)
    begin
      state   <= stage_timer_pkg::ST_IDLE;
      op_cnt  <= 32'h00000000;
      rel_cnt <= 19'h00000;
    end
    else
    begin
      case (state)
        stage_timer_pkg::ST_IDLE:
        begin
          op_cnt <= 32'h00000000;
          if (pickup)
            state <= stage_timer_pkg::ST_TIMING;
        end
        stage_timer_pkg::ST_TIMING:
        begin
          if (!pickup && ctrl[stage_timer_pkg::CTRL_DELAYED])
          begin
            state   <= stage_timer_pkg::ST_RELEASE;
            rel_cnt <= 19'h00000;
            if (!ctrl[stage_timer_pkg::CTRL_OPRST])
              op_cnt <= 32'h00000000;
          end
          else if (!pickup)
          begin
            state  <= stage_timer_pkg::ST_IDLE;
            op_cnt <= 32'h00000000;
          end
          else if (tick && op_cnt != 32'hFFFFFFFF)
            op_cnt <= op_cnt + 32'h00000001;
        end
        stage_timer_pkg::ST_RELEASE:
        begin
          if (pickup)
            state <= stage_timer_pkg::ST_TIMING;
          else if (expire)
          begin
            state  <= stage_timer_pkg::ST_IDLE;
            op_cnt <= 32'h00000000;
          end
          else if (tick)
          begin
            rel_cnt <= rel_cnt + 19'h00001;
            // Without continuation the count is left as it stood at the drop.
            if (ctrl[stage_timer_pkg::CTRL_CONT] && op_cnt != 32'hFFFFFFFF)
              op_cnt <= op_cnt + 32'h00000001;
          end
        end
        default:
        begin
          state  <= stage_timer_pkg::ST_IDLE;
          op_cnt <= 32'h00000000;
        end
      endcase
    end
  end

  // Forced START and TRIP are ORed with the measured ones; blocking overrides both; a forced phase mask replaces the measured one.
  always_ff @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      START      <= 1'b0;
      TRIP       <= 1'b0;
      BLOCKED    <= 1'b0;
      PHASE_MASK <= 3'h0;
    end
    else
    begin
      START   <= !blk && (state != stage_timer_pkg::ST_IDLE || (forcing && (force_code ==
                 stage_timer_pkg::FORCE_START || force_code == stage_timer_pkg::FORCE_TRIP)));
      TRIP    <= !blk && (real_trip || (forcing
                 && force_code == stage_timer_pkg::FORCE_TRIP));
      BLOCKED <= blk;
      if (forcing && force_code != stage_timer_pkg::FORCE_NORMAL)
        PHASE_MASK <= ctrl[stage_timer_pkg::CTRL_PHASE_LO +: 3];
      else
        PHASE_MASK <= {3{state != stage_timer_pkg::ST_IDLE}};
    end
  end

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);

  a_pickup_rise: assert property (I_MEAS > iset |=> pickup)
    else $error("pickup did not rise above threshold");
  a_pickup_hyst: assert property (pickup && im_pct >= iset_pct |=> pickup)
    else $error("pickup dropped inside hysteresis band");
  a_release_hold: assert property (state == stage_timer_pkg::ST_RELEASE && !blk |=> START)
    else $error("start not held during release");
  a_instant_drop: assert property (state == stage_timer_pkg::ST_TIMING && !pickup && !blk
      && !ctrl[stage_timer_pkg::CTRL_DELAYED] && !forcing |=> ##1 !START)
    else $error("start not cleared immediately");
  a_expire_idle: assert property (expire |=> state == stage_timer_pkg::ST_IDLE
      && op_cnt == 32'h00000000)
    else $error("release expiry did not clear stage");
  a_drop_clear: assert property (state == stage_timer_pkg::ST_TIMING && !pickup && !blk
      && !ctrl[stage_timer_pkg::CTRL_OPRST] |=> op_cnt == 32'h00000000)
    else $error("counter not cleared at drop");
  a_count_cont: assert property (state == stage_timer_pkg::ST_RELEASE && !pickup && tick
      && !expire && !blk && ctrl[stage_timer_pkg::CTRL_CONT] && op_cnt != 32'hFFFFFFFF
      |=> op_cnt == $past(op_cnt) + 32'h00000001)
    else $error("counter stopped during release");
  a_count_freeze: assert property (state == stage_timer_pkg::ST_RELEASE && !expire && !blk
      && !ctrl[stage_timer_pkg::CTRL_CONT] |=> op_cnt == $past(op_cnt))
    else $error("counter moved while frozen");
  a_no_rel_trip: assert property (state == stage_timer_pkg::ST_RELEASE
      && !(forcing && force_code == stage_timer_pkg::FORCE_TRIP) |=> !TRIP)
    else $error("trip issued during release");
  a_force_trip: assert property (forcing && force_code == stage_timer_pkg::FORCE_TRIP
      |=> TRIP && START)
    else $error("forced trip not shown");
  a_real_forced: assert property (forcing && force_code == stage_timer_pkg::FORCE_NORMAL
      && state != stage_timer_pkg::ST_IDLE |=> START)
    else $error("real start masked by forcing");
  a_trip_reach: assert property (real_trip && !blk |=> TRIP)
    else $error("trip missing at operate delay");
endmodule

// File: verification/test_stage_delay_timer.sv
// Self-checking testbench for the protection stage delay timer.
`timescale 1ns/1ps
module test_stage_delay_timer;
  logic        clk;
  logic        rst;
  logic [15:0] i_meas;
  logic [7:0]  adr;
  logic [31:0] dat;
  logic [3:0]  sel;
  logic        we;
  logic        cyc;
  logic        stb;
  logic        ack;
  logic [31:0] rdat;
  logic        start;
  logic        trip;
  logic        blocked;
  logic [2:0]  phase;
  logic        irq;
  logic        tseen;
  logic [31:0] r;
  int          fail_count;
  int          samples_checked;
  int          n;
  int          d;
  int          v1;
  int          le;

  // One millisecond is ten clocks here, so every cycle count below is ten times its millisecond figure.
  stage_delay_timer #(.TICK_CYCLES(10)) stage_delay_timer_i (
    .CLK_SYS    (clk),
    .RST        (rst),
    .I_MEAS     (i_meas),
    .WB_ADR_I   (adr),
    .WB_DAT_I   (dat),
    .WB_SEL_I   (sel),
    .WB_WE_I    (we),
    .WB_CYC_I   (cyc),
    .WB_STB_I   (stb),
    .WB_ACK_O   (ack),
    .WB_DAT_O   (rdat),
    .START      (start),
    .TRIP       (trip),
    .BLOCKED    (blocked),
    .PHASE_MASK (phase),
    .IRQ        (irq)
  );

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Sticky trip monitor, so a short trip pulse cannot slip between two samples.
  always @(posedge clk)
    if (trip === 1'b1)
      tseen <= 1'b1;

  task test_done;
    $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] lo, input logic [31:0] hi);
    samples_checked++;
    if ($isunknown(g) || g < lo || g > hi)
    begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask

  // Classic single Wishbone cycle; entered just after a rising edge.
  task wb(input logic w, input logic [7:0] a, input logic [15:0] v, output logic [31:0] q);
    int k;
    k = 0;
    adr <= a;
    dat <= {16'h0000, v};
    we  <= w;
    sel <= 4'h3;
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk);
    while (ack !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    if (k >= 20)
      fail_count++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    @(posedge clk);
  endtask

  // Waits, bounded, for START (s = 0) or TRIP (s = 1) to reach level v.
  task wt(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (((s == 0) ? start : trip) !== v && c < lim)
    begin
      @(posedge clk);
      c++;
    end
  endtask

  initial
  begin
    repeat (50000) @(posedge clk);
    fail_count++;
    test_done;
  end

  initial
  begin
    rst = 1'b1; i_meas = 16'h0000; adr = 8'h00; dat = 32'h0; sel = 4'h0;
    we = 1'b0; cyc = 1'b0; stb = 1'b0; tseen = 1'b0; fail_count = 0; samples_checked = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    wb(0, 8'h00, 16'h0000, r); chk(r, 32'h6, 32'h6);
    wb(0, 8'h0C, 16'h0000, r); chk(r, 60 / 5, 60 / 5);
    wb(0, 8'h24, 16'h0000, r); chk(r, 32'h0, 32'h0);
    wb(1, 8'h20, 16'h0002, r);
    // Reciprocal curve at 2.4 In against 1.2 In with a dial of 0.05 s.
    d = (5 * 10 * 240 * 1000) / (339 * 240 - 236 * 120);
    i_meas <= 16'h00F0;
    wt(0, 1, 10, n); chk(n, 2, 5);
    // The delay register needs a full division pass after the current changes.
    wt(1, 1, 5000, n); chk(n, d * 10 - 30, d * 10 + 30);
    wb(0, 8'h18, 16'h0000, r); chk(r, d - 1, d + 1);
    wb(0, 8'h14, 16'h0000, r); chk(r, d, d + 2);
    i_meas <= 16'h0075;
    repeat (20) @(posedge clk);
    wb(0, 8'h10, 16'h0000, r); chk(r[0], 1, 1);
    i_meas <= 16'h0074;
    wt(1, 0, 10, n); chk(n, 1, 4);
    wt(0, 0, 2000, n); chk(n, 570, 615);
    wb(0, 8'h14, 16'h0000, r); chk(r, 0, 0);
    wb(0, 8'h1C, 16'h0000, r); chk(r, 32'h7, 32'h7);
    chk(irq, 1, 1);
    wb(1, 8'h20, 16'h0000, r);
    repeat (2) @(posedge clk);
    chk(irq, 0, 0);
    wb(1, 8'h1C, 16'h0007, r);
    wb(0, 8'h1C, 16'h0000, r); chk(r, 0, 0);
    i_meas <= 16'h0078;
    repeat (30) @(posedge clk);
    wb(0, 8'h10, 16'h0000, r); chk(r[0], 0, 0);
    // Frozen counter during a 200 ms release, then resumed by a new pick-up.
    wb(1, 8'h0C, 16'h0028, r);
    i_meas <= 16'h00F0;
    repeat (1000) @(posedge clk);
    i_meas <= 16'h0000;
    repeat (20) @(posedge clk);
    wb(0, 8'h14, 16'h0000, r); v1 = int'(r); chk(r, 95, 101);
    repeat (300) @(posedge clk);
    wb(0, 8'h14, 16'h0000, r); chk(r, v1, v1);
    i_meas <= 16'h00F0;
    wt(1, 1, 3000, n); chk(n, (d - v1) * 10 - 30, (d - v1) * 10 + 30);
    i_meas <= 16'h0000;
    wt(0, 0, 3000, n);
    wb(0, 8'h14, 16'h0000, r); chk(r, 0, 0);
    // Counter keeps running past the delay in release, yet no trip may follow.
    wb(1, 8'h00, 16'h000E, r);
    tseen <= 1'b0;
    i_meas <= 16'h00F0;
    repeat (1000) @(posedge clk);
    i_meas <= 16'h0000;
    repeat (20) @(posedge clk);
    wb(0, 8'h14, 16'h0000, r); v1 = int'(r);
    repeat (300) @(posedge clk);
    wb(0, 8'h14, 16'h0000, r); chk(r, v1 + 28, v1 + 33);
    wt(0, 0, 3000, n); chk(tseen, 0, 0);
    wb(0, 8'h14, 16'h0000, r); chk(r, 0, 0);
    // Counter cleared at drop while start is still held.
    wb(1, 8'h00, 16'h0002, r);
    i_meas <= 16'h00F0;
    repeat (500) @(posedge clk);
    i_meas <= 16'h0000;
    repeat (30) @(posedge clk);
    wb(0, 8'h14, 16'h0000, r); chk(r, 0, 0);
    chk(start, 1, 1);
    wt(0, 0, 3000, n);
    wb(1, 8'h00, 16'h0000, r);
    i_meas <= 16'h00F0;
    wt(0, 1, 10, n);
    i_meas <= 16'h0000;
    wt(0, 0, 10, n); chk(n, 1, 5);
    // Logarithmic curve: a dial of 1.0 first, then 0.1 at 100 In for a negative delay.
    le = $rtoi(5800.0 - 1350.0 * $ln(240.0 / (1.0 * 120.0)));
    wb(1, 8'h00, 16'h0007, r);
    wb(1, 8'h08, 16'h0064, r);
    i_meas <= 16'h00F0;
    repeat (100) @(posedge clk);
    wb(0, 8'h18, 16'h0000, r); chk(r, le - 90, le + 90);
    i_meas <= 16'h0000;
    wt(0, 0, 3000, n);
    wb(1, 8'h08, 16'h000A, r);
    i_meas <= 16'h2710;
    wt(1, 1, 60, n); chk(n, 2, 12);
    wb(0, 8'h18, 16'h0000, r); chk(r, 0, 0);
    i_meas <= 16'h0000;
    wt(0, 0, 3000, n);
    // Forcing codes, each with phase mask 101, and a real pick-up under forcing.
    wb(1, 8'h00, 16'h0536, r);
    repeat (3) @(posedge clk);
    chk(start, 1, 1);
    chk(phase, 5, 5);
    wb(1, 8'h00, 16'h0556, r);
    repeat (3) @(posedge clk);
    chk(trip, 1, 1);
    wb(1, 8'h00, 16'h0576, r);
    i_meas <= 16'h00F0;
    repeat (30) @(posedge clk);
    chk(start, 0, 0);
    chk(blocked, 1, 1);
    wb(1, 8'h00, 16'h0516, r);
    wt(0, 1, 10, n); chk(start, 1, 1);
    i_meas <= 16'h0000;
    wb(1, 8'h00, 16'h0006, r);
    wt(0, 0, 3000, n);
    wb(1, 8'h14, 16'hFFFF, r);
    wb(0, 8'h14, 16'h0000, r); chk(r, 0, 0);
    test_done;
  end
endmodule
